//--- logic/ome_oscillator_enable.sv
// oscillator force-on request bank with an AXI4-Lite register port
`timescale 1ns/1ns
module ome_oscillator_enable import ome_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [OSC_HI:OSC_LO] module_osc_request,
	input wire logic [OSC_HI:OSC_LO] osc_usable,
	output logic [OSC_HI:OSC_LO] osc_run,
	output logic [OSC_HI:OSC_LO] osc_ready,
	output logic [2:0] fast_osc_freq_code,
	output logic [5:0] fast_osc_freq_mhz,
	output logic secondary_osc_power_select
);
	logic [OSC_HI:OSC_LO] force_r;
	logic [OSC_HI:OSC_LO] run_r;
	logic [OSC_HI:OSC_LO] ready_r;
	logic [2:0] freq_r;
	logic [5:0] mhz_r;
	logic power_r;
	logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
	logic aw_full_r, w_full_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [31:0] wdata_r;
	logic wlane0_r;
	logic [1:0] bresp_r, rresp_r;
	logic [31:0] rdata_r;

	wire aw_take = s_axi_awvalid && awready_r;
	wire w_take = s_axi_wvalid && wready_r;
	wire wr_do = aw_full_r && w_full_r && !bvalid_r;
	wire wr_lane = wr_do && wlane0_r;
	wire wr_force = wr_lane && (waddr_r == OFS_FORCE);
	wire wr_freq = wr_lane && (waddr_r == OFS_FREQ) && (wdata_r[2:0] != FREQ_RESERVED);
	wire wr_power = wr_lane && (waddr_r == OFS_POWER);
	wire wr_hit = (waddr_r == OFS_FORCE) || (waddr_r == OFS_FREQ) || (waddr_r == OFS_POWER);
	wire ar_take = s_axi_arvalid && arready_r;
	wire rd_hit = (s_axi_araddr == OFS_FORCE) || (s_axi_araddr == OFS_FREQ) ||
		(s_axi_araddr == OFS_READY) || (s_axi_araddr == OFS_POWER);
	// the two low bits of the force register are never stored, so they read zero
	wire [31:0] rd_mux = (s_axi_araddr == OFS_FORCE) ? {24'h00_0000, force_r, 2'h0} :
		(s_axi_araddr == OFS_FREQ) ? {29'h0000_0000, freq_r} :
		(s_axi_araddr == OFS_READY) ? {24'h00_0000, ready_r, 2'h0} :
		(s_axi_araddr == OFS_POWER) ? {31'h0000_0000, power_r} : DATA_ZERO;
	wire [OSC_HI:OSC_LO] run_nxt = force_r | module_osc_request;

	// write channels are taken independently, committed once both are held
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			waddr_r <= OFS_FORCE;
			wdata_r <= DATA_ZERO;
			wlane0_r <= 1'b0;
		end else if (ce) begin
			if (aw_take) begin
				aw_full_r <= 1'b1;
				awready_r <= 1'b0;
				waddr_r <= s_axi_awaddr;
			end else if (!aw_full_r && !bvalid_r) begin
				awready_r <= 1'b1;
			end
			if (w_take) begin
				w_full_r <= 1'b1;
				wready_r <= 1'b0;
				wdata_r <= s_axi_wdata;
				wlane0_r <= s_axi_wstrb[0];
			end else if (!w_full_r && !bvalid_r) begin
				wready_r <= 1'b1;
			end
			if (wr_do) begin
				bvalid_r <= 1'b1;
				bresp_r <= wr_hit ? RESP_OKAY : RESP_SLVERR;
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
			end else if (bvalid_r && s_axi_bready) begin
				bvalid_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= DATA_ZERO;
			rresp_r <= RESP_OKAY;
		end else if (ce) begin
			if (ar_take) begin
				arready_r <= 1'b0;
				rvalid_r <= 1'b1;
				rdata_r <= rd_mux;
				rresp_r <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_r && s_axi_rready) begin
				rvalid_r <= 1'b0;
			end else if (!rvalid_r) begin
				arready_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			force_r <= FORCE_RST;
			freq_r <= FREQ_RST;
			power_r <= 1'b0;
		end else if (ce) begin
			if (wr_force) begin
				force_r <= wdata_r[OSC_HI:OSC_LO];
			end
			if (wr_freq) begin
				freq_r <= wdata_r[2:0];
			end
			if (wr_power) begin
				power_r <= wdata_r[0];
			end
		end
	end

	// oscillator run and ready; a start-up delay is the usable input's concern
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			run_r <= FORCE_RST;
			ready_r <= FORCE_RST;
			mhz_r <= 6'h00;
		end else if (ce) begin
			run_r <= run_nxt;
			ready_r <= run_r & osc_usable;
			mhz_r <= ome_freq_mhz(freq_r);
		end
	end

	assign s_axi_awready = awready_r;
	assign s_axi_wready = wready_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_arready = arready_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign osc_run = run_r;
	assign osc_ready = ready_r;
	assign fast_osc_freq_code = freq_r;
	assign fast_osc_freq_mhz = mhz_r;
	// secondary drive level follows the power select whenever it runs
	assign secondary_osc_power_select = power_r;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	chk_sec_force_run: assert property (ce && force_r[BIT_SEC] |=> run_r[BIT_SEC])
		else $error("secondary forced on but not running");
	chk_sec_module_run: assert property (ce && module_osc_request[BIT_SEC] |=> run_r[BIT_SEC])
		else $error("secondary module request ignored");
	chk_conv_force_run: assert property (ce && force_r[BIT_CONV] |=> run_r[BIT_CONV])
		else $error("converter RC forced on but not running");
	chk_conv_idle_off: assert property (ce && !force_r[BIT_CONV] && !module_osc_request[BIT_CONV]
		|=> !run_r[BIT_CONV])
		else $error("converter RC running without any request");
	chk_conv_module_run: assert property (ce && module_osc_request[BIT_CONV] |=> run_r[BIT_CONV])
		else $error("converter RC module request ignored");
	chk_sec_idle_off: assert property (ce && !force_r[BIT_SEC] && !module_osc_request[BIT_SEC]
		|=> !run_r[BIT_SEC])
		else $error("secondary running without any request");
	chk_fast_force_run: assert property (ce && force_r[BIT_FAST] |=> run_r[BIT_FAST])
		else $error("fast oscillator forced on but not running");
	chk_reset_clears_req: assert property (disable iff (1'b0) !aresetn |=> force_r == FORCE_RST)
		else $error("request bits not cleared by reset");
	chk_low_bits_zero: assert property (ce && ar_take && s_axi_araddr == OFS_FORCE
		|=> rdata_r[1:0] == 2'h0)
		else $error("unimplemented request bits read nonzero");
	// refused writes must leave stored settings untouched; the next two checks each compare two of force, freq and power, and chk_rsvd_keeps_freq compares freq only
	chk_narrow_write_kept: assert property (ce && wr_do && !wlane0_r |=> $stable(force_r) && $stable(freq_r))
		else $error("write without low byte lane changed a setting");
	chk_bad_write_kept: assert property (ce && wr_do && !wr_hit |=> $stable(force_r) && $stable(power_r))
		else $error("unmapped write changed a setting");
	chk_freq_not_rsvd: assert property (freq_r != FREQ_RESERVED)
		else $error("reserved frequency code stored");
	chk_rsvd_keeps_freq: assert property (ce && wr_lane && waddr_r == OFS_FREQ && wdata_r[2:0] == FREQ_RESERVED
		|=> $stable(freq_r))
		else $error("reserved frequency code changed the setting");
	chk_freq_32_mhz: assert property (ce && freq_r == 3'h6 |=> mhz_r == 6'h20)
		else $error("code 110 not mapped to 32 MHz");
	chk_freq_16_mhz: assert property (ce && freq_r == 3'h5 |=> mhz_r == 6'h10)
		else $error("code 101 not mapped to 16 MHz");
	chk_ready_needs_run: assert property (ce && ready_r[BIT_EXT] |-> $past(run_r[BIT_EXT]))
		else $error("ready flag set while oscillator disabled");
	chk_ready_follow: assert property (ce && run_r[BIT_MID] && osc_usable[BIT_MID] |=> ready_r[BIT_MID])
		else $error("ready flag missing for usable oscillator");

	cov_force_write: cover property (wr_force && wdata_r[BIT_SEC]);
	cov_ready_read: cover property (ar_take && s_axi_araddr == OFS_READY);
	cov_bad_read: cover property (ar_take && !rd_hit);
	cov_narrow_write: cover property (wr_do && !wlane0_r);
	cov_rsvd_freq: cover property (wr_lane && waddr_r == OFS_FREQ && wdata_r[2:0] == FREQ_RESERVED);
endmodule : ome_oscillator_enable

//--- logic/ome_pkg.sv
// constants for the oscillator force-on request bank
// Function
// - secondary force-on bit 3 keeps secondary oscillator running at selected power level
// - with bit 3 clear, other modules may still switch the secondary oscillator on
// - converter RC force-on bit 2 keeps that oscillator running regardless of requests
// - with bit 2 clear, converter RC runs only while another module asks
// - frequency code 110 is 32 MHz, 101 is 16 MHz, 111 reserved
// - each oscillator ready flag is one only when enabled and usable
package ome_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [ADDR_W-1:0] OFS_FORCE = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_FREQ = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_READY = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_POWER = 4'hC;
	localparam int unsigned BIT_EXT = 7;
	localparam int unsigned BIT_FAST = 6;
	localparam int unsigned BIT_MID = 5;
	localparam int unsigned BIT_SLOW = 4;
	localparam int unsigned BIT_SEC = 3;
	localparam int unsigned BIT_CONV = 2;
	localparam int unsigned OSC_LO = 2;
	localparam int unsigned OSC_HI = 7;
	localparam logic [5:0] FORCE_RST = 6'h00;
	localparam logic [2:0] FREQ_RESERVED = 3'h7;
	localparam logic [2:0] FREQ_RST = 3'h6;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [31:0] DATA_ZERO = 32'h0000_0000;
	typedef enum logic [2:0] {
		OME_F1, OME_F2, OME_F4, OME_F8, OME_F12, OME_F16, OME_F32, OME_FRSV
	} ome_freq_t;

	// nominal frequency in MHz per code; reserved code reads as zero
	function automatic logic [5:0] ome_freq_mhz(input logic [2:0] code);
		case (ome_freq_t'(code))
			OME_F1: ome_freq_mhz = 6'h01;
			OME_F2: ome_freq_mhz = 6'h02;
			OME_F4: ome_freq_mhz = 6'h04;
			OME_F8: ome_freq_mhz = 6'h08;
			OME_F12: ome_freq_mhz = 6'h0C;
			OME_F16: ome_freq_mhz = 6'h10;
			OME_F32: ome_freq_mhz = 6'h20;
			default: ome_freq_mhz = 6'h00;
		endcase
	endfunction : ome_freq_mhz
endpackage : ome_pkg

//--- testbench/ome_oscillator_enable_test.sv
// self-checking bench for the oscillator force-on request bank
`timescale 1ns/1ns
module ome_oscillator_enable_test import ome_pkg::*; ;
	logic aclk, aresetn, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, secondary_osc_power_select;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d, q;
	logic [3:0] s_axi_wstrb;
	logic [3:0] strb = 4'hF;
	logic [1:0] s_axi_bresp, s_axi_rresp, r, rr;
	logic [OSC_HI:OSC_LO] module_osc_request, osc_usable, osc_run, osc_ready, req, use_v;
	logic [2:0] fast_osc_freq_code, fc;
	logic [5:0] fast_osc_freq_mhz;
	int fails = 0;
	int compares = 0;
	ome_oscillator_enable dut (.aclk, .aresetn, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.module_osc_request, .osc_usable, .osc_run, .osc_ready, .fast_osc_freq_code, .fast_osc_freq_mhz,
		.secondary_osc_power_select);
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] v, output logic [1:0] rs);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a; s_axi_wdata <= v; s_axi_wstrb <= strb;
		s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 0;
		if (n == 64) begin fails++; print_verdict(); end
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [31:0] v);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
		for (n = 0; n < 64; n++) begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) break;
		end
		v = s_axi_rdata;
		rr = s_axi_rresp;
		s_axi_rready <= 0;
		if (n == 64) begin fails++; print_verdict(); end
	endtask : rd
	function automatic logic [31:0] mhz(input logic [2:0] c);
		case (c)
			3'h0: mhz = 1; 3'h1: mhz = 2; 3'h2: mhz = 4; 3'h3: mhz = 8;
			3'h4: mhz = 12; 3'h5: mhz = 16; 3'h6: mhz = 32; default: mhz = 0;
		endcase
	endfunction : mhz
	initial begin
		{aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 0;
		module_osc_request = 0; osc_usable = 0;
		repeat (3) @(posedge aclk);
		aresetn <= 1; ce <= 1;
		void'($urandom(17560));
		rd(OFS_FORCE, q); chk("force reset", 0, q);
		rd(OFS_FREQ, q); chk("freq reset", 6, q);
		rd(OFS_POWER, q); chk("power reset", 0, q);
		chk("mhz reset", 32, 32'(fast_osc_freq_mhz));
		for (int i = 0; i < 14; i++) begin
			// corner cases first: all forced with no requests, then none forced
			d = (i == 0) ? 32'hFFFF_FFFF : (i == 1) ? 32'h0000_0000 : $urandom;
			req = (i < 2) ? 6'h00 : (i == 2) ? 6'h3F : 6'($urandom);
			use_v = (i == 0) ? 6'h3F : 6'($urandom);
			module_osc_request <= req; osc_usable <= use_v;
			wr(OFS_FORCE, d, r); chk("force bresp", 32'(RESP_OKAY), 32'(r));
			rd(OFS_FORCE, q); chk("force readback", d & 32'h0000_00FC, q);
			chk("force rresp", 32'(RESP_OKAY), 32'(rr));
			repeat (3) @(posedge aclk);
			chk("osc_run", 32'(d[7:2] | req), 32'(osc_run));
			chk("osc_ready", 32'((d[7:2] | req) & use_v), 32'(osc_ready));
			rd(OFS_READY, q); chk("ready reg", 32'((d[7:2] | req) & use_v) << 2, q);
		end
		fc = 3'h6;
		for (int c = 0; c < 8; c++) begin
			wr(OFS_FREQ, 32'(c), r); chk("freq bresp", 32'(RESP_OKAY), 32'(r));
			if (c != 7) fc = 3'(c);
			rd(OFS_FREQ, q); chk("freq readback", 32'(fc), q);
			repeat (3) @(posedge aclk);
			chk("freq code", 32'(fc), 32'(fast_osc_freq_code));
			chk("freq mhz", mhz(fc), 32'(fast_osc_freq_mhz));
		end
		wr(OFS_POWER, 32'h0000_0001, r);
		repeat (2) @(posedge aclk);
		chk("power select", 1, 32'(secondary_osc_power_select));
		wr(OFS_READY, 32'h0000_00FC, r); chk("ready write bresp", 32'(RESP_SLVERR), 32'(r));
		// corner cases: narrow strobe, unmapped write and read, clock enable held low
		wr(OFS_FORCE, 32'h0000_0000, r);
		module_osc_request <= 6'h00;
		strb = 4'hE;
		wr(OFS_FORCE, 32'h0000_00FC, r); chk("narrow bresp", 32'(RESP_OKAY), 32'(r));
		strb = 4'hF;
		wr(4'h1, 32'h0000_00FC, r); chk("bad write bresp", 32'(RESP_SLVERR), 32'(r));
		rd(OFS_FORCE, q); chk("force kept", 0, q);
		rd(4'h2, q); chk("bad read data", 0, q);
		chk("bad read rresp", 32'(RESP_SLVERR), 32'(rr));
		ce <= 0;
		module_osc_request <= 6'h3F;
		repeat (3) @(posedge aclk);
		chk("run frozen", 0, 32'(osc_run));
		ce <= 1;
		repeat (3) @(posedge aclk);
		chk("run released", 32'h0000_003F, 32'(osc_run));
		wr(OFS_FREQ, 32'h0000_0001, r);
		wr(OFS_FORCE, 32'h0000_00FF, r);
		module_osc_request <= 0;
		aresetn <= 0;
		repeat (2) @(posedge aclk);
		aresetn <= 1;
		rd(OFS_FORCE, q); chk("force after reset", 0, q);
		repeat (2) @(posedge aclk);
		chk("run after reset", 0, 32'(osc_run));
		chk("freq after reset", 32'(FREQ_RST), 32'(fast_osc_freq_code));
		chk("power after reset", 0, 32'(secondary_osc_power_select));
		print_verdict();
	end
endmodule : ome_oscillator_enable_test
